// ### pkg/rdtm_pkg.sv
/*
  Shared constants and types of the remote diode temperature monitor core.
  Assumes one 200 MHz clock and temperatures in signed eighths of a degree.
*/
`default_nettype none
package rdtm_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 200;
  localparam int SMB_TIMEOUT_US = 25000;
  localparam int SMB_TIMEOUT_CYC = SMB_TIMEOUT_US * CLK_MHZ;
  localparam int PER_16HZ_US = 62500;
  localparam int PER_4HZ_US = 250000;
  localparam int PER_1HZ_US = 1000000;
  localparam int PER_0P4HZ_US = 2500000;
  localparam int PER_16HZ_CYC = PER_16HZ_US * CLK_MHZ;
  localparam int PER_4HZ_CYC = PER_4HZ_US * CLK_MHZ;
  localparam int PER_1HZ_CYC = PER_1HZ_US * CLK_MHZ;
  localparam int PER_0P4HZ_CYC = PER_0P4HZ_US * CLK_MHZ;
  // ==========================================================
  // Encodings and reset values
  localparam logic [1:0] RATE_0P4HZ = 2'h0;
  localparam logic [1:0] RATE_1HZ = 2'h1;
  localparam logic [1:0] RATE_4HZ = 2'h2;
  localparam logic [1:0] RATE_16HZ = 2'h3;
  localparam logic [1:0] ADDR_LOW = 2'h0;
  localparam logic [1:0] ADDR_MID = 2'h1;
  localparam logic [1:0] ADDR_HIGH = 2'h2;
  localparam logic [1:0] ADDR_SETTLE = 2'h3;
  localparam int FILT_SHIFT = 2;
  localparam logic [31:0] CNT_RST = 32'h0;
  localparam logic signed [12:0] TEMP_RST = 13'sh0;
  localparam logic signed [12:0] SGN_MIN = -13'sd1024;
  localparam logic signed [12:0] SGN_MAX = 13'sd1023;
  localparam logic signed [12:0] UNS_MAX = 13'sd2047;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOCAL, SEQ_REMOTE} rdtm_seq_t;
endpackage
`default_nettype wire

// ### rtl/rdtm_core.sv
/*
  Digital core of a two channel temperature monitor: conversion sequencer,
  remote offset and filter, alarms with hysteresis, pin control, SMBus
  timeout watchdog. Assumes an ADC front end and settings logic on REF_CLK;
  pin inputs are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Local and remote channels are converted in turn, each result 11 bits.
// - Results are encoded signed -128..127.875 or unsigned 0..255.875.
// - Each alarm asserts while any unmasked channel exceeds its threshold.
// - Present levels of the critical output, and of the shared pin in overtemperature mode, are readable as status bits.
// - One hysteresis applies to all alarms; release needs temp below thr-hyst.
// - The remote result passes an optional filter; local is never filtered.
// - A programmable offset is added to the remote measurement.
// - Conversion interval is programmable from 16 Hz down to 0.4 Hz.
// - In standby a one-shot write runs exactly one conversion cycle.
// - After reset the shared pin is a three-level address select input.
// - Configured as overtemperature output, the shared pin is open drain low.
// - The critical alarm output is active low and open drain.
// - The serial interface abandons a transfer on SMBus clock timeout.
module rdtm_core #(
  parameter int PER_16HZ = rdtm_pkg::PER_16HZ_CYC,
  parameter int PER_4HZ = rdtm_pkg::PER_4HZ_CYC,
  parameter int PER_1HZ = rdtm_pkg::PER_1HZ_CYC,
  parameter int PER_0P4HZ = rdtm_pkg::PER_0P4HZ_CYC,
  parameter int SMB_TMO = rdtm_pkg::SMB_TIMEOUT_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic STANDBY,
  input wire logic ONE_SHOT,
  input wire logic [1:0] CONV_RATE,
  input wire logic TEMP_FORMAT,
  input wire logic FILTER_EN,
  input wire logic signed [11:0] REMOTE_OFFSET,
  input wire logic signed [12:0] CRIT_THRESH_LOCAL,
  input wire logic signed [12:0] CRIT_THRESH_REMOTE,
  input wire logic signed [12:0] OS_THRESH_LOCAL,
  input wire logic signed [12:0] OS_THRESH_REMOTE,
  input wire logic [11:0] HYSTERESIS,
  input wire logic [1:0] CRIT_MASK,
  input wire logic [1:0] OS_MASK,
  input wire logic OS_PIN_MODE,
  input wire logic ADC_DONE,
  input wire logic signed [11:0] ADC_DATA,
  input wire logic ADC_DIODE_FAULT,
  input wire logic ADDR_SELECT_INPUT_HI,
  input wire logic ADDR_SELECT_INPUT_LO,
  input wire logic SMB_CLK_I,
  input wire logic SMB_DAT_DRIVE,
  output logic ADC_START,
  output logic ADC_REMOTE_SEL,
  output logic CONV_BUSY,
  output logic [10:0] LOCAL_TEMP,
  output logic [10:0] REMOTE_TEMP,
  output logic DIODE_FAULT,
  output logic CRIT_STATUS,
  output logic OS_STATUS,
  output logic CRITICAL_ALARM_N_O,
  output logic CRITICAL_ALARM_N_OE,
  output logic ALARM_OR_ADDR_SELECT_PIN_O,
  output logic ALARM_OR_ADDR_SELECT_PIN_OE,
  output logic [1:0] SLAVE_ADDR_SEL,
  output logic SMB_DAT_O,
  output logic SMB_DAT_OE,
  output logic SMB_TIMEOUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  localparam logic signed [12:0] TEMP_RST = rdtm_pkg::TEMP_RST;

  // Clamp a temperature to the chosen output format
  function automatic logic [10:0] enc(input logic signed [12:0] t,
                                      input logic fmt);
    logic signed [12:0] c;
    c = t;
    if (fmt) begin
      if (t < TEMP_RST) c = TEMP_RST;
      if (t > rdtm_pkg::UNS_MAX) c = rdtm_pkg::UNS_MAX;
    end else begin
      if (t < rdtm_pkg::SGN_MIN) c = rdtm_pkg::SGN_MIN;
      if (t > rdtm_pkg::SGN_MAX) c = rdtm_pkg::SGN_MAX;
    end
    return c[10:0];
  endfunction

  // ==========================================================
  // Conversion sequencer
  rdtm_pkg::rdtm_seq_t seq_q, seq_d;
  logic [31:0] tmr_q, tmr_d, per;
  logic pend_q, pend_d, start_q, start_d, rsel_q, rsel_d, busy_q, busy_d;
  logic signed [12:0] loc_q, loc_d, rem_q, rem_d, rx;
  logic signed [13:0] fdiff;
  logic fv_q, fv_d, flt_q, flt_d;
  logic [10:0] lo_q, lo_d, ro_q, ro_d;

  // Interval select, timer, one-shot, sampling and encoding
  always_comb begin
    case (CONV_RATE)
      rdtm_pkg::RATE_16HZ: per = PER_16HZ;
      rdtm_pkg::RATE_4HZ: per = PER_4HZ;
      rdtm_pkg::RATE_1HZ: per = PER_1HZ;
      default: per = PER_0P4HZ;
    endcase
    seq_d = seq_q;
    start_d = 1'b0;
    rsel_d = rsel_q;
    loc_d = loc_q;
    rem_d = rem_q;
    fv_d = fv_q;
    flt_d = flt_q;
    tmr_d = (tmr_q >= per - 32'h1) ? rdtm_pkg::CNT_RST : tmr_q + 32'h1;
    // one-shot request held, new request wins over its consumption
    pend_d = STANDBY & (pend_q | ONE_SHOT);
    rx = 13'(ADC_DATA) + 13'(REMOTE_OFFSET);
    fdiff = 14'(rx) - 14'(rem_q);
    case (seq_q)
      rdtm_pkg::SEQ_IDLE: begin
        if ((!STANDBY && tmr_q >= per - 32'h1) || (STANDBY && pend_q)) begin
          seq_d = rdtm_pkg::SEQ_LOCAL;
          start_d = 1'b1;
          rsel_d = 1'b0;
          pend_d = ONE_SHOT & STANDBY;
        end
      end
      rdtm_pkg::SEQ_LOCAL: begin
        if (ADC_DONE) begin
          loc_d = 13'(ADC_DATA);
          seq_d = rdtm_pkg::SEQ_REMOTE;
          start_d = 1'b1;
          rsel_d = 1'b1;
        end
      end
      rdtm_pkg::SEQ_REMOTE: begin
        if (ADC_DONE) begin
          seq_d = rdtm_pkg::SEQ_IDLE;
          // diode fault keeps last good value
          flt_d = ADC_DIODE_FAULT;
          if (!ADC_DIODE_FAULT) begin
            // offset added; optional first order filter
            if (FILTER_EN && fv_q)
              rem_d = rem_q + 13'(fdiff >>> rdtm_pkg::FILT_SHIFT);
            else
              rem_d = rx;
            fv_d = 1'b1;
          end
        end
      end
      default: seq_d = rdtm_pkg::SEQ_IDLE;
    endcase
    busy_d = (seq_d != rdtm_pkg::SEQ_IDLE);
    lo_d = enc(loc_d, TEMP_FORMAT);
    ro_d = enc(rem_d, TEMP_FORMAT);
  end

  // Sequencer registers
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      seq_q <= rdtm_pkg::SEQ_IDLE;
      tmr_q <= rdtm_pkg::CNT_RST;
      pend_q <= 1'b0;
      start_q <= 1'b0;
      rsel_q <= 1'b0;
      busy_q <= 1'b0;
      loc_q <= TEMP_RST;
      rem_q <= TEMP_RST;
      fv_q <= 1'b0;
      flt_q <= 1'b0;
      lo_q <= 11'h0;
      ro_q <= 11'h0;
    end else begin
      seq_q <= seq_d;
      tmr_q <= tmr_d;
      pend_q <= pend_d;
      start_q <= start_d;
      rsel_q <= rsel_d;
      busy_q <= busy_d;
      loc_q <= loc_d;
      rem_q <= rem_d;
      fv_q <= fv_d;
      flt_q <= flt_d;
      lo_q <= lo_d;
      ro_q <= ro_d;
    end
  end
  assign ADC_START = start_q;
  assign ADC_REMOTE_SEL = rsel_q;
  assign CONV_BUSY = busy_q;
  assign LOCAL_TEMP = lo_q;
  assign REMOTE_TEMP = ro_q;
  assign DIODE_FAULT = flt_q;

  // ==========================================================
  // Alarm flags: entry 0/1 overtemp local/remote, 2/3 critical
  logic [3:0] alm_q;
  logic signed [12:0] thr [4];
  assign thr[0] = OS_THRESH_LOCAL;
  assign thr[1] = OS_THRESH_REMOTE;
  assign thr[2] = CRIT_THRESH_LOCAL;
  assign thr[3] = CRIT_THRESH_REMOTE;

  for (genvar i = 0; i < 4; i++) begin : g_alm
    logic alm_d;
    logic signed [13:0] t, th, tr;
    assign t = (i % 2 == 1) ? 14'(rem_q) : 14'(loc_q);
    assign th = t + 14'($signed({1'b0, HYSTERESIS}));
    assign tr = 14'(thr[i]);
    // set above threshold; release below threshold minus hysteresis
    always_comb begin
      alm_d = alm_q[i] ? !(th < tr) : (t > tr);
    end
    always_ff @(posedge REF_CLK) begin
      if (!RST_N) alm_q[i] <= 1'b0;
      else alm_q[i] <= alm_d;
    end
    a_hyst_hold: assert property (alm_q[i] &&
      t >= tr - $signed({2'b00, HYSTERESIS}) |=> alm_q[i])
      else $error("alarm released inside hysteresis band");
  end

  // ==========================================================
  // Alarm pins, address select capture
  logic crit_any, os_any, crit_q, os_q, oe_os_q, low_q;
  logic [1:0] hi_s_q, lo_s_q, acnt_q, acnt_d, addr_q, addr_d;
  assign crit_any = |(alm_q[3:2] & ~CRIT_MASK);
  assign os_any = |(alm_q[1:0] & ~OS_MASK);

  // Address sampled once after synchronisers settle
  always_comb begin
    acnt_d = acnt_q;
    addr_d = addr_q;
    if (acnt_q != rdtm_pkg::ADDR_SETTLE) begin
      acnt_d = acnt_q + 2'h1;
      // three-level select from the pin comparators
      if (acnt_d == rdtm_pkg::ADDR_SETTLE)
        addr_d = hi_s_q[1] ? rdtm_pkg::ADDR_HIGH :
                 lo_s_q[1] ? rdtm_pkg::ADDR_LOW : rdtm_pkg::ADDR_MID;
    end
  end

  // Pin registers
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      crit_q <= 1'b0;
      os_q <= 1'b0;
      oe_os_q <= 1'b0;
      low_q <= 1'b0;
      hi_s_q <= 2'h0;
      lo_s_q <= 2'h0;
      acnt_q <= 2'h0;
      addr_q <= rdtm_pkg::ADDR_MID;
    end else begin
      crit_q <= crit_any;
      os_q <= os_any;
      oe_os_q <= OS_PIN_MODE & os_any;
      low_q <= 1'b0;
      hi_s_q <= {hi_s_q[0], ADDR_SELECT_INPUT_HI};
      lo_s_q <= {lo_s_q[0], ADDR_SELECT_INPUT_LO};
      acnt_q <= acnt_d;
      addr_q <= addr_d;
    end
  end
  // critical pin pulled low while alarm; status mirrors pins, the shared pin only in overtemperature mode
  assign CRITICAL_ALARM_N_O = low_q;
  assign CRITICAL_ALARM_N_OE = crit_q;
  assign CRIT_STATUS = crit_q;
  assign OS_STATUS = os_q;
  // shared pin driven low only in overtemperature mode
  assign ALARM_OR_ADDR_SELECT_PIN_O = low_q;
  assign ALARM_OR_ADDR_SELECT_PIN_OE = oe_os_q;
  assign SLAVE_ADDR_SEL = addr_q;

  // ==========================================================
  // SMBus clock low timeout watchdog
  logic [1:0] sck_q;
  logic [31:0] low_cnt_q, low_cnt_d;
  logic hold_q, hold_d, tmo_q, tmo_d, doe_q, doe_d;
  // clock held low too long abandons the transfer
  always_comb begin
    low_cnt_d = sck_q[1] ? rdtm_pkg::CNT_RST :
                (low_cnt_q < SMB_TMO ? low_cnt_q + 32'h1 : low_cnt_q);
    tmo_d = !sck_q[1] && (low_cnt_q == SMB_TMO - 1);
    hold_d = !sck_q[1] && (hold_q || tmo_d);
    doe_d = SMB_DAT_DRIVE && !hold_d;
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sck_q <= 2'h3;
      low_cnt_q <= rdtm_pkg::CNT_RST;
      hold_q <= 1'b0;
      tmo_q <= 1'b0;
      doe_q <= 1'b0;
    end else begin
      sck_q <= {sck_q[0], SMB_CLK_I};
      low_cnt_q <= low_cnt_d;
      hold_q <= hold_d;
      tmo_q <= tmo_d;
      doe_q <= doe_d;
    end
  end
  assign SMB_DAT_O = low_q;
  assign SMB_DAT_OE = doe_q;
  assign SMB_TIMEOUT = tmo_q;

  // ==========================================================
  // Checks
  sequence s_local_done;
    seq_q == rdtm_pkg::SEQ_LOCAL && ADC_DONE;
  endsequence
  sequence s_oneshot_req;
    STANDBY && ONE_SHOT && seq_q == rdtm_pkg::SEQ_IDLE && !pend_q;
  endsequence
  a_remote_follows: assert property (s_local_done |=>
    ADC_START && ADC_REMOTE_SEL && loc_q == 13'($past(ADC_DATA)))
    else $error("remote conversion did not follow local");
  a_format_range: assert property (TEMP_FORMAT && $stable(TEMP_FORMAT)
    && loc_q < TEMP_RST |-> LOCAL_TEMP == 11'h0)
    else $error("unsigned format shows negative value");
  a_crit_pin: assert property (crit_any |=> CRITICAL_ALARM_N_OE
    && !CRITICAL_ALARM_N_O) else $error("critical pin not driven low");
  a_status_pin: assert property (CRIT_STATUS == CRITICAL_ALARM_N_OE &&
    (!$past(OS_PIN_MODE) || OS_STATUS == ALARM_OR_ADDR_SELECT_PIN_OE))
    else $error("alarm status differs from pin");
  a_offset_raw: assert property (seq_q == rdtm_pkg::SEQ_REMOTE && ADC_DONE
    && !FILTER_EN && !ADC_DIODE_FAULT |=>
    rem_q == 13'($past(ADC_DATA)) + 13'($past(REMOTE_OFFSET)))
    else $error("remote offset not applied");
  a_rate_bound: assert property ($stable(CONV_RATE) |-> tmr_q < per)
    else $error("conversion timer beyond interval");
  a_standby_quiet: assert property (STANDBY && !ONE_SHOT && !pend_q &&
    seq_q == rdtm_pkg::SEQ_IDLE |=> seq_q == rdtm_pkg::SEQ_IDLE)
    else $error("conversion started in standby without one-shot");
  a_oneshot_run: assert property (s_oneshot_req ##1 STANDBY |=>
    ADC_START && !ADC_REMOTE_SEL) else $error("one-shot did not start");
  a_pin_input: assert property (!OS_PIN_MODE |=>
    !ALARM_OR_ADDR_SELECT_PIN_OE) else $error("address pin driven");
  a_tmo_release: assert property (SMB_TIMEOUT |-> !SMB_DAT_OE)
    else $error("data driven after timeout");
  a_fault_flag: assert property (seq_q == rdtm_pkg::SEQ_REMOTE && ADC_DONE
    && ADC_DIODE_FAULT |=> DIODE_FAULT)
    else $error("diode fault not flagged");
endmodule
`default_nettype wire

// ### bench/rdtm_adc_model.sv
/*
  Behavioural converter front end that answers the core's start pulses.
  Assumes the core's REF_CLK; returned codes are set by the testbench.
*/
`timescale 1ns/1ps
`default_nettype none
module rdtm_adc_model #(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic start,
  input wire logic remote_sel,
  input wire logic signed [11:0] loc_val,
  input wire logic signed [11:0] rem_val,
  input wire logic rem_fault,
  output logic done,
  output logic signed [11:0] data,
  output logic fault
);
  int cnt = 0;
  logic sel_q = 1'b0;
  // ==========================================================
  // Conversion timing
  // Result after LAT cycles; data toggles while idle
  always @(posedge clk) begin
    done <= 1'b0;
    if (start) begin
      cnt <= LAT;
      sel_q <= remote_sel;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      done <= 1'b1;
      data <= sel_q ? rem_val : loc_val;
      fault <= sel_q & rem_fault;
    end else begin
      data <= ~data;
      fault <= ~fault;
    end
  end
endmodule
`default_nettype wire

// ### bench/rdtm_core_tb.sv
/*
  Self-checking testbench of the temperature monitor core.
  Assumes rdtm_core with shortened periods and the converter model.
*/
`timescale 1ns/1ps
`default_nettype none
module rdtm_core_tb;
  logic ref_clk = 0, rst_n = 0, standby = 1, one_shot = 0, temp_format = 0;
  logic filter_en = 0, os_pin_mode = 0, rem_fault = 0, addr_hi = 1;
  logic addr_lo = 0, smb_clk_i = 1, smb_dat_drive = 0;
  logic [1:0] conv_rate = 2'h3, crit_mask = 2'h0, os_mask = 2'h0;
  logic signed [11:0] remote_offset = 12'sh0, loc_val = 0, rem_val = 0;
  logic signed [12:0] crit_l = 13'sh0fff, crit_r = 13'sh0fff;
  logic signed [12:0] os_l = 13'sh0fff, os_r = 13'sh0fff;
  logic [11:0] hyst = 12'h010;
  logic adc_done, adc_fault, adc_start, adc_sel, conv_busy, diode_fault;
  logic signed [11:0] adc_data;
  logic [10:0] local_temp, remote_temp;
  logic crit_status, os_status, crit_o, crit_oe, sh_o, sh_oe;
  logic smb_dat_o, smb_dat_oe, smb_timeout;
  logic [1:0] slave_addr_sel;
  int mismatches = 0, compares = 0, starts = 0;
  // ==========================================================
  // Clock, start counter, design and model
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (adc_start === 1'b1) starts++;
  rdtm_core #(.PER_16HZ(20), .PER_4HZ(40), .PER_1HZ(80), .PER_0P4HZ(100),
    .SMB_TMO(50)) uut (.REF_CLK(ref_clk), .RST_N(rst_n),
    .STANDBY(standby), .ONE_SHOT(one_shot), .CONV_RATE(conv_rate),
    .TEMP_FORMAT(temp_format), .FILTER_EN(filter_en),
    .REMOTE_OFFSET(remote_offset), .CRIT_THRESH_LOCAL(crit_l),
    .CRIT_THRESH_REMOTE(crit_r), .OS_THRESH_LOCAL(os_l),
    .OS_THRESH_REMOTE(os_r), .HYSTERESIS(hyst), .CRIT_MASK(crit_mask),
    .OS_MASK(os_mask), .OS_PIN_MODE(os_pin_mode), .ADC_DONE(adc_done),
    .ADC_DATA(adc_data), .ADC_DIODE_FAULT(adc_fault),
    .ADDR_SELECT_INPUT_HI(addr_hi), .ADDR_SELECT_INPUT_LO(addr_lo),
    .SMB_CLK_I(smb_clk_i), .SMB_DAT_DRIVE(smb_dat_drive),
    .ADC_START(adc_start), .ADC_REMOTE_SEL(adc_sel),
    .CONV_BUSY(conv_busy), .LOCAL_TEMP(local_temp),
    .REMOTE_TEMP(remote_temp), .DIODE_FAULT(diode_fault),
    .CRIT_STATUS(crit_status), .OS_STATUS(os_status),
    .CRITICAL_ALARM_N_O(crit_o), .CRITICAL_ALARM_N_OE(crit_oe),
    .ALARM_OR_ADDR_SELECT_PIN_O(sh_o), .ALARM_OR_ADDR_SELECT_PIN_OE(sh_oe),
    .SLAVE_ADDR_SEL(slave_addr_sel), .SMB_DAT_O(smb_dat_o),
    .SMB_DAT_OE(smb_dat_oe), .SMB_TIMEOUT(smb_timeout));
  rdtm_adc_model #(.LAT(3)) adc (.clk(ref_clk), .start(adc_start),
    .remote_sel(adc_sel), .loc_val(loc_val), .rem_val(rem_val),
    .rem_fault(rem_fault), .done(adc_done), .data(adc_data),
    .fault(adc_fault));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One-shot conversion in standby, then wait for alarms to settle
  task automatic convert(input logic [11:0] l, input logic [11:0] r,
                         input logic f);
    int n;
    @(posedge ref_clk);
    loc_val <= l;
    rem_val <= r;
    rem_fault <= f;
    one_shot <= 1'b1;
    @(posedge ref_clk);
    one_shot <= 1'b0;
    n = 0;
    while (conv_busy !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    while (conv_busy === 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
    chk("conversion done", 1, n < 80);
    tick(5);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_oneshot;
    int s0;
    @(posedge ref_clk);
    remote_offset <= 12'sh010;
    s0 = starts;
    convert(12'h0c8, 12'h100, 1'b0);
    chk("starts", 2, starts - s0);
    chk("local", 11'h0c8, local_temp);
    chk("remote", 11'h110, remote_temp);
    tick(150);
    chk("starts idle", 2, starts - s0);
    @(posedge ref_clk);
    remote_offset <= 12'sh0;
  endtask
  task automatic t_format;
    convert(12'hfb0, 12'h7f0, 1'b0);
    chk("signed local", 11'h7b0, local_temp);
    chk("signed clamp", 11'h3ff, remote_temp);
    @(posedge ref_clk);
    temp_format <= 1'b1;
    convert(12'hfb0, 12'h7f0, 1'b0);
    chk("unsigned local", 11'h000, local_temp);
    chk("unsigned remote", 11'h7f0, remote_temp);
    @(posedge ref_clk);
    temp_format <= 1'b0;
  endtask
  task automatic t_filter;
    convert(12'h050, 12'h100, 1'b0);
    @(posedge ref_clk);
    filter_en <= 1'b1;
    convert(12'h060, 12'h200, 1'b0);
    chk("filtered", 11'h140, remote_temp);
    chk("local unfiltered", 11'h060, local_temp);
    @(posedge ref_clk);
    filter_en <= 1'b0;
  endtask
  task automatic t_fault;
    convert(12'h050, 12'h300, 1'b1);
    chk("fault flag", 1, diode_fault);
    chk("remote kept", 11'h140, remote_temp);
    convert(12'h050, 12'h050, 1'b0);
    chk("fault clear", 0, diode_fault);
  endtask
  task automatic t_alarm;
    @(posedge ref_clk);
    crit_l <= 13'sh0100;
    os_l <= 13'sh00f0;
    os_pin_mode <= 1'b1;
    convert(12'h101, 12'h050, 1'b0);
    chk("crit set", 1, crit_status);
    chk("crit pin", 2'h2, {crit_oe, crit_o});
    chk("os pin", 3'h6, {os_status, sh_oe, sh_o});
    @(posedge ref_clk);
    crit_mask <= 2'h1;
    tick(4);
    chk("crit masked", 2'h0, {crit_status, crit_oe});
    @(posedge ref_clk);
    crit_mask <= 2'h0;
    convert(12'h0f1, 12'h050, 1'b0);
    chk("crit held", 1, crit_status);
    convert(12'h0ef, 12'h050, 1'b0);
    chk("crit released", 2'h0, {crit_status, crit_oe});
    chk("os held", 1, os_status);
    @(posedge ref_clk);
    os_mask <= 2'h1;
    tick(4);
    chk("os masked", 2'h0, {os_status, sh_oe});
    @(posedge ref_clk);
    os_mask <= 2'h0;
    os_pin_mode <= 1'b0;
    tick(4);
    chk("addr mode", 2'h2, {os_status, sh_oe});
  endtask
  task automatic t_rate;
    int per[4] = '{100, 80, 40, 20};
    int n;
    @(posedge ref_clk);
    standby <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      conv_rate <= i[1:0];
      for (int k = 0; k < 3; k++) begin
        n = 0;
        do begin
          tick(1);
          n++;
        end while (!(adc_start === 1'b1 && adc_sel === 1'b0) && n < 300);
      end
      chk("interval", per[i], n);
    end
    @(posedge ref_clk);
    standby <= 1'b1;
    tick(150);
  endtask
  task automatic t_timeout;
    int n;
    @(posedge ref_clk);
    smb_dat_drive <= 1'b1;
    tick(4);
    chk("drive on", 1, smb_dat_oe);
    @(posedge ref_clk);
    smb_clk_i <= 1'b0;
    n = 0;
    while (smb_timeout !== 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
    chk("timeout time", 1, n >= 50 && n <= 54);
    tick(2);
    chk("drive released", 0, smb_dat_oe);
    @(posedge ref_clk);
    smb_clk_i <= 1'b1;
    tick(6);
    chk("drive again", 1, smb_dat_oe);
    @(posedge ref_clk);
    smb_dat_drive <= 1'b0;
  endtask
  // Mid-run reset with the shared pin strapped low
  task automatic t_reset;
    @(posedge ref_clk);
    addr_hi <= 1'b0;
    addr_lo <= 1'b1;
    rst_n <= 1'b0;
    tick(3);
    chk("reset status", 3'h0, {crit_status, os_status, conv_busy});
    chk("reset temp", 11'h0, local_temp);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    chk("addr after reset", rdtm_pkg::ADDR_MID, slave_addr_sel);
    tick(4);
    chk("addr low", rdtm_pkg::ADDR_LOW, slave_addr_sel);
    chk("pins after reset", 2'h0, {sh_oe, crit_oe});
  endtask
  // ==========================================================
  // Verdict and main sequence
  task automatic summarize;
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(5);
    chk("addr sel", rdtm_pkg::ADDR_HIGH, slave_addr_sel);
    chk("pins idle", 2'h0, {sh_oe, crit_oe});
    t_oneshot();
    t_format();
    t_filter();
    t_fault();
    t_alarm();
    t_rate();
    t_reset();
    t_timeout();
    summarize();
  end
endmodule
`default_nettype wire
